// >>> src/pss_consts.svh
// constants of the scan supervisor: offsets, fields, resets, timing
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PSS_OFS_CTRL      8'h00
`define PSS_OFS_DETECT    8'h04
`define PSS_OFS_CONST     8'h08
`define PSS_OFS_WDOG      8'h0C
`define PSS_OFS_TBASE     8'h10
`define PSS_OFS_STATUS    8'h14
`define PSS_OFS_LOGIDX    8'h18
`define PSS_OFS_LOGDATA   8'h1C
// ---------------------------------------------------------------
// control and status field positions
// ---------------------------------------------------------------
`define PSS_CTRL_CLEAR    0
`define PSS_CTRL_HOLD     1
`define PSS_CTRL_PTEN     2
`define PSS_CTRL_CONST    3
`define PSS_CTRL_CARD     4
`define PSS_CTRL_SEL_LO   8
`define PSS_STAT_WDOG     2
// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define PSS_DETECT_RST    8'h14
`define PSS_DETECT_MIN    8'h14
`define PSS_DETECT_MAX    8'hC8
`define PSS_CONST_RST     15'h0001
`define PSS_CONST_MIN     15'h0001
`define PSS_CONST_MAX     15'h7530
`define PSS_WDOG_RST      15'h00C8
`define PSS_WDOG_MIN      15'h000A
`define PSS_WDOG_MAX      15'h7530
`define PSS_TBASE_RST     15'h000A
`define PSS_TBASE_MIN     15'h0001
`define PSS_TBASE_MAX     15'h07D0
`define PSS_LOG_DEPTH     20
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PSS_CLK_NS        25
`define PSS_MS_NS         1000000
`define PSS_TENTH_MS      100
`endif

// >>> src/pss_pkg.sv
// types of the scan supervisor
package pss_pkg;
  typedef enum logic [3:0] {
    ST_DETECT = 4'b0001,
    ST_STOP   = 4'b0010,
    ST_SCAN   = 4'b0100,
    ST_WAIT   = 4'b1000
  } pss_state_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       card;
    logic       cscan;
    logic       pt_en;
    logic       hold;
    logic       clear;
  } pss_ctrl_t;

  typedef struct packed {
    logic [14:0] const_ms;
    logic [14:0] wdog_ms;
    logic [14:0] tbase_ms;
    logic [7:0]  detect_t;
  } pss_times_t;
endpackage

// >>> src/pss_scan_supervisor.sv
// scan supervisor: run/stop, scan pacing, watchdog, error log, axi4-lite slave
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pss_consts.svh"
module pss_scan_supervisor #(
  parameter int MS_CYCLES = `PSS_MS_NS / `PSS_CLK_NS,
  parameter int NPTS      = 8,
  parameter int CODE_W    = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              mode_sw,
  input  wire logic [NPTS-1:0]   in_pts,
  input  wire logic              scan_done,
  input  wire logic              err_valid,
  input  wire logic [CODE_W-1:0] err_code,
  input  wire logic              card_ready,
  output logic                   err_ready,
  output logic                   card_valid,
  output logic [CODE_W-1:0]      card_data,
  output logic                   run,
  output logic                   io_ready,
  output logic                   scan_start,
  output logic                   clear_nonlatched,
  output logic                   outputs_off,
  output logic                   wdog_err,
  output logic                   periodic_interrupt_zero,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  localparam int LD = `PSS_LOG_DEPTH;
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NPTS:0] s1_ff, s2_ff, s3_ff, pin_ff, pins_raw;
  // top bit is the mode switch, so no select ever runs past in_pts
  assign pins_raw = {mode_sw, in_pts};
  for (genvar i = 0; i <= NPTS; i++) begin : g_sync
    // change accepted once second and third stages agree
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_ff[i]  <= 1'b0;
        s2_ff[i]  <= 1'b0;
        s3_ff[i]  <= 1'b0;
        pin_ff[i] <= 1'b0;
      end else begin
        s1_ff[i] <= pins_raw[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) pin_ff[i] <= s3_ff[i];
      end
    end
  end
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  pss_pkg::pss_ctrl_t  ctrl_ff, nxt_ctrl;
  pss_pkg::pss_times_t tm_ff, nxt_tm;
  logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic        awr_ff, nxt_awr, wr_ff, nxt_wr, arr_ff, nxt_arr;
  logic [7:0]  awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
  logic [4:0]  lidx_ff, nxt_lidx;
  logic        wdog_clr;
  logic [CODE_W-1:0] log_mem [LD];
  logic [4:0]  cnt_ff, wp_ff;

  function automatic logic [14:0] clamp15(logic [31:0] v, logic [14:0] lo, logic [14:0] hi);
    if (v < 32'(lo)) return lo;
    if (v > 32'(hi)) return hi;
    return v[14:0];
  endfunction

  always_comb begin
    nxt_aw = aw_ff; nxt_w = w_ff; nxt_awa = awa_ff; nxt_wd = wd_ff;
    nxt_bv = bv_ff; nxt_br = br_ff; nxt_rv = rv_ff; nxt_rr = rr_ff; nxt_rd = rd_ff;
    nxt_ctrl = ctrl_ff; nxt_tm = tm_ff; nxt_lidx = lidx_ff; wdog_clr = 1'b0;
    if (s_axi_awvalid && !aw_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) nxt_bv = 1'b0;
    if (aw_ff && w_ff && !bv_ff) begin
      nxt_aw = 1'b0; nxt_w = 1'b0; nxt_bv = 1'b1; nxt_br = 2'h0;
      // byte strobes ignored: every field is written whole
      unique case (awa_ff)
        `PSS_OFS_CTRL: nxt_ctrl = pss_pkg::pss_ctrl_t'({wd_ff[`PSS_CTRL_SEL_LO+:3], wd_ff[4:0]});
        `PSS_OFS_DETECT: nxt_tm.detect_t = 8'(clamp15(wd_ff, 15'(`PSS_DETECT_MIN),
                                                   15'(`PSS_DETECT_MAX)));
        `PSS_OFS_CONST: nxt_tm.const_ms = clamp15(wd_ff, `PSS_CONST_MIN, `PSS_CONST_MAX);
        `PSS_OFS_WDOG:  nxt_tm.wdog_ms  = clamp15(wd_ff, `PSS_WDOG_MIN, `PSS_WDOG_MAX);
        `PSS_OFS_TBASE: nxt_tm.tbase_ms = clamp15(wd_ff, `PSS_TBASE_MIN, `PSS_TBASE_MAX);
        `PSS_OFS_STATUS: wdog_clr = wd_ff[`PSS_STAT_WDOG];
        `PSS_OFS_LOGIDX: nxt_lidx = (wd_ff < 32'(LD)) ? wd_ff[4:0] : 5'h00;
        default: nxt_br = 2'h2;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) nxt_rv = 1'b0;
    if (s_axi_arvalid && !rv_ff) begin
      nxt_rv = 1'b1; nxt_rr = 2'h0; nxt_rd = 32'h0000_0000;
      unique case (s_axi_araddr)
        `PSS_OFS_CTRL:    nxt_rd = {21'h0, ctrl_ff.sel, 3'h0, ctrl_ff[4:0]};
        `PSS_OFS_DETECT:  nxt_rd = {24'h0, tm_ff.detect_t};
        `PSS_OFS_CONST:   nxt_rd = {17'h0, tm_ff.const_ms};
        `PSS_OFS_WDOG:    nxt_rd = {17'h0, tm_ff.wdog_ms};
        `PSS_OFS_TBASE:   nxt_rd = {17'h0, tm_ff.tbase_ms};
        `PSS_OFS_STATUS:  nxt_rd = {19'h0, cnt_ff, 5'h0, wdog_err, io_ready, run};
        `PSS_OFS_LOGIDX:  nxt_rd = {27'h0, lidx_ff};
        `PSS_OFS_LOGDATA: nxt_rd = 32'(log_mem[lidx_ff]);
        default:          nxt_rr = 2'h2;
      endcase
    end
    // readies kept in flops of their own so the bus sees no gate
    nxt_awr = !nxt_aw;
    nxt_wr  = !nxt_w;
    nxt_arr = !nxt_rv;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_ff <= 1'b0; w_ff <= 1'b0; bv_ff <= 1'b0; rv_ff <= 1'b0;
      awa_ff <= 8'h00; wd_ff <= 32'h0000_0000; rd_ff <= 32'h0000_0000;
      br_ff <= 2'h0; rr_ff <= 2'h0; lidx_ff <= 5'h00;
      awr_ff <= 1'b1;
      wr_ff <= 1'b1;
      arr_ff <= 1'b1;
      ctrl_ff <= pss_pkg::pss_ctrl_t'(8'h01);
      tm_ff <= {`PSS_CONST_RST, `PSS_WDOG_RST, `PSS_TBASE_RST, `PSS_DETECT_RST};
    end else begin
      aw_ff <= nxt_aw; w_ff <= nxt_w; bv_ff <= nxt_bv; rv_ff <= nxt_rv;
      awa_ff <= nxt_awa; wd_ff <= nxt_wd; rd_ff <= nxt_rd;
      br_ff <= nxt_br; rr_ff <= nxt_rr; lidx_ff <= nxt_lidx;
      awr_ff <= nxt_awr;
      wr_ff <= nxt_wr;
      arr_ff <= nxt_arr;
      ctrl_ff <= nxt_ctrl; tm_ff <= nxt_tm;
    end
  end
  assign s_axi_awready = awr_ff;
  assign s_axi_wready  = wr_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;
  // ---------------------------------------------------------------
  // run/stop and scan pacing
  // ---------------------------------------------------------------
  pss_pkg::pss_state_t st_ff, nxt_st;
  logic [15:0] fpre_ff, nxt_fpre, spre_ff, nxt_spre;
  logic [14:0] tb_ff, nxt_tb, el_ff, nxt_el;
  logic [6:0]  tms_ff, nxt_tms;
  logic [7:0]  det_ff, nxt_det;
  logic run_ff, nxt_run, rdy_ff, nxt_rdy, ss_ff, nxt_ss, clr_ff, nxt_clr;
  logic off_ff, nxt_off, wd_err_ff, nxt_wd_err, pi_ff, nxt_pi;
  logic ftick, stick, run_cmd;

  always_comb begin
    ftick = (fpre_ff == 16'(MS_CYCLES - 1));
    stick = (spre_ff == 16'(MS_CYCLES - 1));
    nxt_fpre = ftick ? 16'h0000 : fpre_ff + 16'h0001;
    nxt_spre = stick ? 16'h0000 : spre_ff + 16'h0001;
    nxt_pi = 1'b0; nxt_tb = tb_ff;
    if (ftick) begin
      nxt_tb = tb_ff + 15'h0001;
      if (nxt_tb >= tm_ff.tbase_ms) begin
        nxt_tb = 15'h0000;
        nxt_pi = 1'b1;
      end
    end
    nxt_tms = tms_ff; nxt_det = det_ff; nxt_rdy = rdy_ff;
    if (ftick && !rdy_ff) begin
      nxt_tms = tms_ff + 7'h01;
      if (nxt_tms == 7'(`PSS_TENTH_MS)) begin
        nxt_tms = 7'h00;
        nxt_det = det_ff + 8'h01;
        if (nxt_det >= tm_ff.detect_t) nxt_rdy = 1'b1;
      end
    end
    run_cmd = pin_ff[NPTS] && (!ctrl_ff.pt_en || pin_ff[ctrl_ff.sel]);
    nxt_run = run_cmd && rdy_ff;
    nxt_clr = run_ff && !nxt_run && ctrl_ff.clear;
    nxt_off = (run_ff != nxt_run) && !ctrl_ff.hold;
    nxt_el = (stick && el_ff != 15'h7FFF) ? el_ff + 15'h0001 : el_ff;
    nxt_ss = 1'b0; nxt_st = st_ff;
    nxt_wd_err = wd_err_ff && !wdog_clr;
    unique case (st_ff)
      pss_pkg::ST_DETECT: if (rdy_ff) nxt_st = pss_pkg::ST_STOP;
      pss_pkg::ST_STOP:   if (run_ff) nxt_st = pss_pkg::ST_WAIT;
      pss_pkg::ST_SCAN: begin
        // overrun flags error; set beats clear
        if (el_ff >= tm_ff.wdog_ms && stick) nxt_wd_err = 1'b1;
        if (scan_done) nxt_st = pss_pkg::ST_WAIT;
      end
      pss_pkg::ST_WAIT: ;
    endcase
    // hold off until minimum; no wait once it has passed
    // no scan is started in the cycle the run command drops
    if (nxt_st == pss_pkg::ST_WAIT && run_ff && nxt_run &&
        (!ctrl_ff.cscan || st_ff == pss_pkg::ST_STOP || el_ff >= tm_ff.const_ms)) begin
      nxt_st = pss_pkg::ST_SCAN;
      nxt_ss = 1'b1;
    end
    if (!run_ff && st_ff != pss_pkg::ST_DETECT) nxt_st = pss_pkg::ST_STOP;
    if (nxt_ss) begin
      nxt_el = 15'h0000;
      nxt_spre = 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= pss_pkg::ST_DETECT; fpre_ff <= 16'h0000; spre_ff <= 16'h0000;
      tb_ff <= 15'h0000; el_ff <= 15'h0000; tms_ff <= 7'h00; det_ff <= 8'h00;
      run_ff <= 1'b0; rdy_ff <= 1'b0; ss_ff <= 1'b0; clr_ff <= 1'b0;
      off_ff <= 1'b0; wd_err_ff <= 1'b0; pi_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; fpre_ff <= nxt_fpre; spre_ff <= nxt_spre;
      tb_ff <= nxt_tb; el_ff <= nxt_el; tms_ff <= nxt_tms; det_ff <= nxt_det;
      run_ff <= nxt_run; rdy_ff <= nxt_rdy; ss_ff <= nxt_ss; clr_ff <= nxt_clr;
      off_ff <= nxt_off; wd_err_ff <= nxt_wd_err; pi_ff <= nxt_pi;
    end
  end
  assign run = run_ff;
  assign io_ready = rdy_ff;
  assign scan_start = ss_ff;
  assign clear_nonlatched = clr_ff;
  assign outputs_off = off_ff;
  assign wdog_err = wd_err_ff;
  assign periodic_interrupt_zero = pi_ff;
  // ---------------------------------------------------------------
  // error log
  // ---------------------------------------------------------------
  logic [4:0] nxt_cnt, nxt_wp;
  logic [CODE_W-1:0] pend_ff, nxt_pend, cd_ff, nxt_cd;
  logic cv_ff, nxt_cv, er_ff, nxt_er, wr_en;
  logic [CODE_W-1:0] wr_dat;

  always_comb begin
    nxt_cnt = cnt_ff; nxt_wp = wp_ff; nxt_pend = pend_ff; nxt_cd = cd_ff;
    nxt_cv = cv_ff; nxt_er = er_ff; wr_en = 1'b0; wr_dat = err_code;
    if (err_valid && er_ff) begin
      if (cnt_ff == 5'(LD) && ctrl_ff.card) begin
        // oldest to card first; log stalls meanwhile
        nxt_pend = err_code; nxt_cd = log_mem[wp_ff];
        nxt_cv = 1'b1; nxt_er = 1'b0;
      end else begin
        wr_en = 1'b1;
      end
    end
    if (cv_ff && card_ready) begin
      nxt_cv = 1'b0; nxt_er = 1'b1; wr_en = 1'b1; wr_dat = pend_ff;
    end
    if (wr_en) begin
      nxt_wp = (wp_ff == 5'(LD - 1)) ? 5'h00 : wp_ff + 5'h01;
      if (cnt_ff != 5'(LD)) nxt_cnt = cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) log_mem[wp_ff] <= wr_dat;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 5'h00; wp_ff <= 5'h00; pend_ff <= '0; cd_ff <= '0;
      cv_ff <= 1'b0; er_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt; wp_ff <= nxt_wp; pend_ff <= nxt_pend; cd_ff <= nxt_cd;
      cv_ff <= nxt_cv; er_ff <= nxt_er;
    end
  end
  assign err_ready = er_ff;
  assign card_valid = cv_ff;
  assign card_data = cd_ff;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_clear_on_stop: assert property ($fell(run_ff) |-> clr_ff == $past(ctrl_ff.clear))
    else $error("clear pulse wrong at stop");
  chk_outputs_off: assert property ($changed(run_ff) |-> off_ff == !$past(ctrl_ff.hold))
    else $error("outputs off pulse wrong");
  chk_detect_first: assert property (ss_ff |-> rdy_ff && run_ff)
    else $error("scan before detection window");
  chk_point_stops: assert property (ctrl_ff.pt_en && !pin_ff[ctrl_ff.sel] |=> !run_ff)
    else $error("input point did not stop");
  chk_const_wait: assert property (ss_ff && $past(st_ff == pss_pkg::ST_SCAN, 2) &&
                                   $past(ctrl_ff.cscan)
                                   |-> $past(el_ff) >= $past(tm_ff.const_ms))
    else $error("scan started before minimum time");
  chk_no_extra: assert property (st_ff == pss_pkg::ST_SCAN && scan_done && run_ff && nxt_run &&
                                 el_ff >= tm_ff.const_ms |=> ss_ff)
    else $error("overrun scan waited");
  chk_wdog_set: assert property (st_ff == pss_pkg::ST_SCAN && stick &&
                                 el_ff >= tm_ff.wdog_ms |=> wd_err_ff)
    else $error("watchdog not flagged");
  chk_log_bound: assert property (cnt_ff <= 5'(LD) && wp_ff < 5'(LD))
    else $error("log count out of range");
  chk_card_hold: assert property (cv_ff && !card_ready |=> cv_ff && $stable(cd_ff) && !er_ff)
    else $error("card entry dropped");
  chk_wdog_restart: assert property (ss_ff |-> el_ff == 15'h0000 && spre_ff == 16'h0000)
    else $error("scan count not restarted");
  cov_run_stop: cover property (run_ff ##[1:1000] !run_ff);
  cov_const_wait: cover property (st_ff == pss_pkg::ST_WAIT && run_ff ##1 ss_ff);
  cov_card_copy: cover property (cv_ff && card_ready);
  cov_wdog: cover property ($rose(wd_err_ff));
endmodule // pss_scan_supervisor

// >>> test/plc_scan_supervisor_tb.sv
// self-checking bench of the scan supervisor with a memory card model
`timescale 1ns/100ps
`include "pss_consts.svh"
module plc_scan_supervisor_tb;
  localparam int MS = 4;
  logic        clk, rst, mode_sw, scan_done, err_valid, card_ready, err_ready, card_valid;
  logic        run, io_ready, scan_start, clear_nonlatched, outputs_off, wdog_err;
  logic        periodic_interrupt_zero, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  in_pts, s_axi_awaddr, s_axi_araddr, copies;
  logic [15:0] err_code, card_data, last_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, delay, mon;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          err_total, compares, cyc;
  assign mon = {periodic_interrupt_zero, err_ready, scan_start, io_ready};
  pss_scan_supervisor #(.MS_CYCLES(MS), .NPTS(8), .CODE_W(16)) u_dut (
    .clk, .rst, .mode_sw, .in_pts, .scan_done, .err_valid, .err_code, .card_ready,
    .err_ready, .card_valid, .card_data, .run, .io_ready, .scan_start, .clear_nonlatched,
    .outputs_off, .wdog_err, .periodic_interrupt_zero, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pss_card_model u_card (
    .clk, .rst, .delay, .card_valid, .card_data, .card_ready, .last_data, .copies
  );
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic tmo();
    err_total++;
    $display("BAD %0t wait ran out", $time);
    report_and_stop();
  endtask
  // sampled at the falling edge so registered outputs have settled
  task automatic wait_hi(input int b, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mon[b] !== 1'b1 && n < lim);
    if (mon[b] !== 1'b1) tmo();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int   n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end while (tb !== 1'b1 && n < 60);
    s_axi_bready <= 1'b0;
    if (tb !== 1'b1) tmo();
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int   n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end while (tr !== 1'b1 && n < 60);
    s_axi_rready <= 1'b0;
    if (tr !== 1'b1) tmo();
  endtask
  task automatic drv(input logic m, input logic [7:0] p, output int oo, output int cl);
    @(posedge clk);
    mode_sw <= m;
    in_pts  <= p;
    oo = 0;
    cl = 0;
    repeat (12) begin
      @(negedge clk);
      oo += outputs_off;
      cl += clear_nonlatched;
    end
  endtask
  // scan already started; ends when the next one starts
  task automatic scan_once(input int d, output int g);
    repeat (d) @(posedge clk);
    scan_done <= 1'b1;
    @(posedge clk);
    scan_done <= 1'b0;
    wait_hi(1, 3000, g);
    g = g + d;
  endtask
  task automatic push(input logic [15:0] c);
    logic t;
    int   n;
    n = 0;
    @(posedge clk);
    err_valid <= 1'b1;
    err_code  <= c;
    do begin
      @(negedge clk);
      t = err_ready;
      @(posedge clk);
      n++;
    end while (t !== 1'b1 && n < 100);
    err_valid <= 1'b0;
    if (t !== 1'b1) tmo();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // defaults, clamping, unmapped access, detection window
  task automatic sc_regs();
    logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] dflt [5] = '{32'h1, 32'h14, 32'h1, 32'hC8, 32'hA};
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (int i = 0; i < 5; i++) begin
      axr(ofs[i], d, r);
      chk(d, dflt[i]);
    end
    axr(8'h20, d, r);
    chk(r, 2'b10);
    axw(8'h24, 32'h1, r);
    chk(r, 2'b10);
    axw(`PSS_OFS_DETECT, 32'h5, r);
    axr(`PSS_OFS_DETECT, d, r);
    chk(d, 32'h14);
    axw(`PSS_OFS_WDOG, 32'h9999, r);
    axr(`PSS_OFS_WDOG, d, r);
    chk(d, 32'h7530);
    wait_hi(0, 9000, n);
    chk(cyc >= 7990 && cyc <= 8010, 1);
  endtask
  task automatic sc_runstop();
    int         oo, cl;
    logic [1:0] r;
    drv(1'b1, 8'h00, oo, cl);
    chk(run, 1);
    chk(oo, 1);
    chk(cl, 0);
    drv(1'b0, 8'h00, oo, cl);
    chk(oo, 1);
    chk(cl, 1);
    axw(`PSS_OFS_CTRL, 32'h2, r);
    drv(1'b1, 8'h00, oo, cl);
    chk(oo, 0);
    drv(1'b0, 8'h00, oo, cl);
    chk(oo, 0);
    chk(cl, 0);
  endtask
  // run needs both the switch and the selected point
  task automatic sc_point();
    int         oo, cl;
    logic [1:0] r;
    axw(`PSS_OFS_CTRL, 32'h305, r);
    drv(1'b1, 8'h00, oo, cl);
    chk(run, 0);
    drv(1'b1, 8'h08, oo, cl);
    chk(run, 1);
    drv(1'b1, 8'hF7, oo, cl);
    chk(run, 0);
    drv(1'b0, 8'h08, oo, cl);
    chk(run, 0);
  endtask
  task automatic sc_scan();
    int         g;
    logic [1:0] r;
    axw(`PSS_OFS_CONST, 32'h5, r);
    axw(`PSS_OFS_WDOG, 32'hA, r);
    axw(`PSS_OFS_CTRL, 32'h9, r);
    axw(`PSS_OFS_STATUS, 32'h4, r);
    @(posedge clk);
    mode_sw <= 1'b1;
    wait_hi(1, 100, g);
    scan_once(1, g);
    chk(g >= 15 && g <= 24, 1);
    scan_once(30, g);
    chk(g <= 32, 1);
    scan_once(30, g);
    scan_once(30, g);
    chk(wdog_err, 0);
    scan_once(60, g);
    chk(wdog_err, 1);
    axw(`PSS_OFS_STATUS, 32'h4, r);
    @(negedge clk);
    chk(wdog_err, 0);
    @(posedge clk);
    mode_sw <= 1'b0;
  endtask
  // twenty entries, oldest copied to card then replaced
  task automatic sc_log();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    axw(`PSS_OFS_CTRL, 32'h11, r);
    delay <= 4'h5;
    for (int i = 0; i < 21; i++) push(16'h0100 + 16'(i));
    repeat (2) @(negedge clk);
    chk(err_ready, 0);
    chk(card_valid, 1);
    chk(card_data, 16'h0100);
    wait_hi(2, 100, n);
    chk(last_data, 16'h0100);
    chk(copies, 8'h01);
    axr(`PSS_OFS_STATUS, d, r);
    chk(d[12:8], 5'h14);
    axw(`PSS_OFS_LOGIDX, 32'h0, r);
    axr(`PSS_OFS_LOGDATA, d, r);
    chk(d, 32'h0114);
  endtask
  // periodic pulse spacing follows the time base
  task automatic sc_tick();
    int         n;
    logic [1:0] r;
    wait_hi(3, 100, n);
    wait_hi(3, 100, n);
    chk(n, 40);
    axw(`PSS_OFS_TBASE, 32'h2, r);
    wait_hi(3, 100, n);
    wait_hi(3, 100, n);
    chk(n, 8);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= rst ? 0 : cyc + 1;
  end
  initial begin
    {rst, mode_sw, scan_done, err_valid} = 4'hF - 4'h7;
    {in_pts, err_code, delay} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sc_regs();
    sc_runstop();
    sc_point();
    sc_scan();
    sc_log();
    sc_tick();
    report_and_stop();
  end
endmodule // plc_scan_supervisor_tb

// >>> test/pss_card_model.sv
// memory card model that takes the log entries copied out of the supervisor
`timescale 1ns/100ps
module pss_card_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  delay,
  input  wire logic        card_valid,
  input  wire logic [15:0] card_data,
  output logic             card_ready,
  output logic [15:0]      last_data,
  output logic [7:0]       copies
);
  logic [3:0] wait_cnt;
  // ---------------------------------------------------------------
  // card handshake
  // ---------------------------------------------------------------
  // takes the oldest entry, slow by delay cycles
  // delay kept under 15 so the wait count never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt   <= 4'h0;
      card_ready <= 1'b0;
      last_data  <= 16'h0000;
      copies     <= 8'h00;
    end else if (card_valid && card_ready) begin
      card_ready <= 1'b0;
      wait_cnt   <= 4'h0;
      last_data  <= card_data;
      copies     <= copies + 8'h01;
    end else if (card_valid) begin
      card_ready <= (wait_cnt >= delay);
      wait_cnt   <= wait_cnt + 4'h1;
    end
  end
endmodule // pss_card_model
